// File: design/wake_cfg_defs.svh
// Offsets, field positions, reset values and timing counts of the wake configuration bank
`ifndef WAKE_CFG_DEFS_SVH
`define WAKE_CFG_DEFS_SVH

`define WFC_IDX_DLC 8'h2b
`define WFC_IDX_PAYLOAD4 8'h2f
`define WFC_IDX_PAYLOAD3 8'h30
`define WFC_IDX_PAYLOAD2 8'h31
`define WFC_IDX_PAYLOAD1 8'h32
`define WFC_IDX_PAYLOAD0 8'h33
`define WFC_IDX_FD_CFG 8'h34
`define WFC_IDX_TRIM 8'h38
`define WFC_IDX_WAKE_OPT 8'h39
`define WFC_IDX_TRIM_UNLOCK 8'h3e

`define WFC_RST_BYTE 8'h00
`define WFC_RST_DLC 4'h0
`define WFC_RST_UNLOCK 2'h0
`define WFC_UNLOCK_CODE 2'h3

`define WFC_FD_EN_BIT 0
`define WFC_FILT_LSB 1
`define WFC_FILT_MSB 3
`define WFC_BYPASS_BIT 4
`define WFC_ERRDIS_BIT 5
`define WFC_TRIM_MSB 6
`define WFC_TRIM_PRESET_BIT 7
`define WFC_RXSEL_BIT 7
`define WFC_DLC_MSB 3
`define WFC_UNLOCK_MSB 1

`define WFC_CLK_PERIOD_NS 5
`define WFC_FILT_STEP_NS 50
`define WFC_FILT_LONG_NS 700
`define WFC_FILT_STEP_CYC ((`WFC_FILT_STEP_NS + `WFC_CLK_PERIOD_NS - 1) / `WFC_CLK_PERIOD_NS)
`define WFC_FILT_LONG_CYC ((`WFC_FILT_LONG_NS + `WFC_CLK_PERIOD_NS - 1) / `WFC_CLK_PERIOD_NS)
`define WFC_FILT_LONG_CODE 3'h7
`define WFC_MAX_LEN 4'h8
`define WFC_STORED_BYTES 5

`endif

// File: design/wake_cfg_pkg.sv
// Types shared by the wake configuration bank and its helpers
package wake_cfg_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [4:0][7:0] payload_t;
    typedef enum logic [1:0] {
        filt_idle,
        filt_counting,
        filt_dominant
    } filt_state_t;
endpackage : wake_cfg_pkg

// File: design/wake_cfg_if.sv
// Configuration carried from the register bank to the matcher and the dominant filter
`timescale 1ns/10ps
interface wake_cfg_if;
    import wake_cfg_pkg::*;
    payload_t payload;
    logic [3:0] dlc;
    logic fd_en;
    logic [2:0] filt_time;
    modport bank (output payload, output dlc, output fd_en, output filt_time);
    modport matcher (input payload, input dlc);
    modport filter (input fd_en, input filt_time);
endinterface : wake_cfg_if

// File: design/dominant_filter.sv
// Digital dominant filter on the synchronised bus receive level
`timescale 1ns/10ps
`include "wake_cfg_defs.svh"
module dominant_filter
    import wake_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    wake_cfg_if.filter cfg,
    input wire logic rx_bus_dominant_async,
    output logic filtered_dominant
);
    localparam logic [7:0] STEP_CYC = 8'(`WFC_FILT_STEP_CYC);
    localparam logic [7:0] LONG_CYC = 8'(`WFC_FILT_LONG_CYC);

    logic sync_1;
    logic sync_2;
    logic [7:0] count;
    logic [7:0] limit;
    filt_state_t state;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
        end else begin
            sync_1 <= rx_bus_dominant_async;
            sync_2 <= sync_1;
        end
    end

    always_comb begin
        if (cfg.filt_time == `WFC_FILT_LONG_CODE) begin
            limit = LONG_CYC;
        end else begin
            limit = 8'((cfg.filt_time + 3'h1) * STEP_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= filt_idle;
            count <= 8'h00;
        end else if (!sync_2) begin
            state <= filt_idle;
            count <= 8'h00;
        end else begin
            unique case (state)
                filt_idle: begin
                    count <= 8'h01;
                    state <= (limit == 8'h01) ? filt_dominant : filt_counting;
                end
                filt_counting: begin
                    count <= count + 8'h01;
                    if (count + 8'h01 >= limit) begin
                        state <= filt_dominant;
                    end
                end
                filt_dominant: begin
                    count <= count;
                end
            endcase
        end
    end

    // Filter only applies in FD tolerant mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filtered_dominant <= 1'b0;
        end else begin
            filtered_dominant <= cfg.fd_en ? (sync_2 && state == filt_dominant) : sync_2;
        end
    end
endmodule : dominant_filter

// File: design/wake_frame_matcher.sv
// Compares a received wake frame with the stored length code and payload bytes
`timescale 1ns/10ps
`include "wake_cfg_defs.svh"
module wake_frame_matcher
    import wake_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    wake_cfg_if.matcher cfg,
    input wire logic rx_frame_valid,
    input wire logic [3:0] rx_frame_dlc,
    input payload_t rx_frame_data,
    output logic wake_frame_match
);
    logic [3:0] data_len;
    logic bytes_equal;
    logic dlc_equal;

    assign data_len = (rx_frame_dlc >= `WFC_MAX_LEN) ? `WFC_MAX_LEN : rx_frame_dlc;
    assign dlc_equal = (rx_frame_dlc == cfg.dlc);

    always_comb begin
        bytes_equal = 1'b1;
        for (int i = 0; i < `WFC_STORED_BYTES; i++) begin
            if (4'(i) < data_len && rx_frame_data[i] != cfg.payload[i]) begin
                bytes_equal = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_frame_match <= 1'b0;
        end else begin
            wake_frame_match <= rx_frame_valid && dlc_equal && bytes_equal;
        end
    end
endmodule : wake_frame_matcher

// File: design/wake_frame_payload_fd_config.sv
// APB register bank for wake frame payload, FD tolerant mode and oscillator trim
//
// Behaviour
// - Five payload registers hold one byte each
// - Payload and FD config clear on reset
// - Bit 0 enables FD tolerant mode
// - Bits 3:1 select dominant filter time
// - Bit 4 bypasses receiver analog filter
// - Dominant filter never bypassed by bit 4
// - Bit 5 disables counter only with FD
// - Silence timeout clears counter disable bit
// - Trim field writable only when unlocked
// - Trim bit 7 reads factory preset value
// - FD config bits 7:6 read zero
// - Receiver select: 0 low power, 1 standard
// - Length code must match every bit
`timescale 1ns/10ps
`include "wake_cfg_defs.svh"
module wake_frame_payload_fd_config
    import wake_cfg_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter logic [7:0] TRIM_PRESET = 8'h40
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic silence_timeout_expire,
    input wire logic rx_bus_dominant_async,
    input wire logic rx_frame_valid,
    input wire logic [3:0] rx_frame_dlc,
    input payload_t rx_frame_data,
    output logic fd_tolerant_enable,
    output logic [2:0] dominant_filter_time,
    output logic receiver_filter_bypass,
    output logic error_counter_active,
    output logic wake_receiver_select,
    output logic [6:0] oscillator_trim_value,
    output logic filtered_dominant,
    output logic wake_frame_match
);
    // The index decode needs paddr bits 9:2
    generate
        if (ADDR_W < 10) begin : g_addr_check
            $error("ADDR_W must be at least 10");
        end
    endgenerate

    // Configuration bundle shared with the filter and matcher
    wake_cfg_if cfg ();

    // Register state
    payload_t payload;
    logic [3:0] dlc;
    logic [2:0] dominant_filter_time_q;
    logic fd_en_q;
    logic bypass_q;
    logic error_counter_disable;
    logic [6:0] trim_q;
    logic rx_sel_q;
    logic [1:0] trim_unlock;

    // Bus decode
    logic [7:0] idx;
    logic addr_upper_zero;
    logic hit;
    logic [7:0] read_value;
    logic wr_en;
    logic wr_byte;
    logic setup_phase;
    logic unlocked;

    // Register index is the word address; byte offset bits must be zero
    assign idx = paddr[9:2];
    assign addr_upper_zero = (ADDR_W > 10) ? (paddr >> 10) == '0 : 1'b1;
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pwrite && hit;
    assign wr_byte = wr_en && pstrb[0];
    // Every access completes without wait states
    assign pready = 1'b1;
    assign unlocked = (trim_unlock == `WFC_UNLOCK_CODE);

    // Only mapped indices with a clean word address are accepted
    always_comb begin
        hit = 1'b0;
        if (addr_upper_zero && paddr[1:0] == 2'h0) begin
            unique case (idx)
                `WFC_IDX_DLC, `WFC_IDX_PAYLOAD4, `WFC_IDX_PAYLOAD3, `WFC_IDX_PAYLOAD2,
                `WFC_IDX_PAYLOAD1, `WFC_IDX_PAYLOAD0, `WFC_IDX_FD_CFG, `WFC_IDX_TRIM,
                `WFC_IDX_WAKE_OPT, `WFC_IDX_TRIM_UNLOCK: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    // cleared by power-on or soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            payload <= {5{`WFC_RST_BYTE}};
        end else if (soft_reset) begin
            payload <= {5{`WFC_RST_BYTE}};
        end else if (wr_byte) begin
            // Only the addressed byte is loaded
            unique case (idx)
                `WFC_IDX_PAYLOAD4: begin
                    payload[4] <= pwdata[7:0];
                end
                `WFC_IDX_PAYLOAD3: begin
                    payload[3] <= pwdata[7:0];
                end
                `WFC_IDX_PAYLOAD2: begin
                    payload[2] <= pwdata[7:0];
                end
                `WFC_IDX_PAYLOAD1: begin
                    payload[1] <= pwdata[7:0];
                end
                `WFC_IDX_PAYLOAD0: begin
                    payload[0] <= pwdata[7:0];
                end
                // Writes to other registers leave the bytes alone
                default: begin
                    payload <= payload;
                end
            endcase
        end
    end

    // Configured length code used by the matcher
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dlc <= `WFC_RST_DLC;
        end else if (soft_reset) begin
            dlc <= `WFC_RST_DLC;
        end else if (wr_byte && idx == `WFC_IDX_DLC) begin
            dlc <= pwdata[`WFC_DLC_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fd_en_q <= 1'b0;
            dominant_filter_time_q <= 3'h0;
            bypass_q <= 1'b0;
        end else if (soft_reset) begin
            fd_en_q <= 1'b0;
            dominant_filter_time_q <= 3'h0;
            bypass_q <= 1'b0;
        end else if (wr_byte && idx == `WFC_IDX_FD_CFG) begin
            fd_en_q <= pwdata[`WFC_FD_EN_BIT];
            dominant_filter_time_q <= pwdata[`WFC_FILT_MSB:`WFC_FILT_LSB];
            bypass_q <= pwdata[`WFC_BYPASS_BIT];
        end
    end

    // Software may only set the bit outside a timeout cycle
    // hardware clear at silence timeout wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_counter_disable <= 1'b0;
        end else if (soft_reset || silence_timeout_expire) begin
            error_counter_disable <= 1'b0;
        end else if (wr_byte && idx == `WFC_IDX_FD_CFG) begin
            error_counter_disable <= pwdata[`WFC_ERRDIS_BIT];
        end
    end

    // Trim unlock code guarding trim and receiver select
    // The unlock code survives a soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_unlock <= `WFC_RST_UNLOCK;
        end else if (wr_byte && idx == `WFC_IDX_TRIM_UNLOCK) begin
            trim_unlock <= pwdata[`WFC_UNLOCK_MSB:0];
        end
    end

    // Trim is kept across soft reset; power-on reloads the preset
    // A locked write is dropped without an error response
    // trim writes need unlock code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= TRIM_PRESET[`WFC_TRIM_MSB:0];
        end else if (wr_byte && idx == `WFC_IDX_TRIM && unlocked) begin
            trim_q <= pwdata[`WFC_TRIM_MSB:0];
        end
    end

    // A locked write leaves the select untouched
    // receiver select, also behind the unlock code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sel_q <= 1'b0;
        end else if (soft_reset) begin
            rx_sel_q <= 1'b0;
        end else if (wr_byte && idx == `WFC_IDX_WAKE_OPT && unlocked) begin
            rx_sel_q <= pwdata[`WFC_RXSEL_BIT];
        end
    end

    // Read multiplexer; unmapped indices return zero
    always_comb begin
        read_value = 8'h00;
        unique case (idx)
            `WFC_IDX_DLC: begin
                read_value = {4'h0, dlc};
            end
            `WFC_IDX_PAYLOAD4: begin
                read_value = payload[4];
            end
            `WFC_IDX_PAYLOAD3: begin
                read_value = payload[3];
            end
            `WFC_IDX_PAYLOAD2: begin
                read_value = payload[2];
            end
            `WFC_IDX_PAYLOAD1: begin
                read_value = payload[1];
            end
            `WFC_IDX_PAYLOAD0: begin
                read_value = payload[0];
            end
            `WFC_IDX_FD_CFG: begin
                read_value = {2'h0, error_counter_disable, bypass_q, dominant_filter_time_q, fd_en_q};
            end
            `WFC_IDX_TRIM: begin
                read_value = {TRIM_PRESET[`WFC_TRIM_PRESET_BIT], trim_q};
            end
            // Lower option bits are not implemented and read zero
            `WFC_IDX_WAKE_OPT: begin
                read_value = {rx_sel_q, 7'h00};
            end
            `WFC_IDX_TRIM_UNLOCK: begin
                read_value = {6'h00, trim_unlock};
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    // Read data and error are captured in the setup cycle
    // Writes and refused accesses return zero data
    // Both then stand until the next setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= (hit && !pwrite) ? {24'h00_0000, read_value} : 32'h0000_0000;
            pslverr <= !hit;
        end
    end

    // Drive the shared configuration bundle
    assign cfg.payload = payload;
    assign cfg.dlc = dlc;
    assign cfg.fd_en = fd_en_q;
    assign cfg.filt_time = dominant_filter_time_q;

    // Configuration pins come straight from the registers, except the gated error_counter_active
    assign fd_tolerant_enable = fd_en_q;
    assign dominant_filter_time = dominant_filter_time_q;
    assign receiver_filter_bypass = bypass_q;
    // counter disabled only with FD enabled
    assign error_counter_active = !(error_counter_disable && fd_en_q);
    assign wake_receiver_select = rx_sel_q;
    assign oscillator_trim_value = trim_q;

    // Dominant filter runs on the raw receive level
    // It sits outside the analog path, so bypass does not reach it
    dominant_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.filter),
        .rx_bus_dominant_async(rx_bus_dominant_async),
        .filtered_dominant(filtered_dominant)
    );

    // Matcher compares received frames with the stored bytes
    // Its match output follows rx_frame_valid one cycle later, for each cycle with a matching frame
    wake_frame_matcher u_matcher (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.matcher),
        .rx_frame_valid(rx_frame_valid),
        .rx_frame_dlc(rx_frame_dlc),
        .rx_frame_data(rx_frame_data),
        .wake_frame_match(wake_frame_match)
    );
endmodule : wake_frame_payload_fd_config

// File: tb/wake_frame_payload_fd_config_checker.sv
// Port-level assertions for the wake configuration bank
`timescale 1ns/10ps
`include "wake_cfg_defs.svh"
module wake_frame_payload_fd_config_checker
    import wake_cfg_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter logic [7:0] TRIM_PRESET = 8'h40
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic silence_timeout_expire,
    input wire logic rx_bus_dominant_async,
    input wire logic rx_frame_valid,
    input wire logic fd_tolerant_enable,
    input wire logic [2:0] dominant_filter_time,
    input wire logic receiver_filter_bypass,
    input wire logic error_counter_active,
    input wire logic [6:0] oscillator_trim_value,
    input wire logic filtered_dominant,
    input wire logic wake_frame_match
);
    localparam logic [ADDR_W-1:0] A_FD = ADDR_W'(`WFC_IDX_FD_CFG) << 2;
    localparam logic [ADDR_W-1:0] A_TRIM = ADDR_W'(`WFC_IDX_TRIM) << 2;
    logic setup_rd;
    logic acc_wr;
    logic [7:0] hi_cnt;
    logic [7:0] filt_n;
    assign setup_rd = psel && !penable && !pwrite;
    assign acc_wr = psel && penable && pwrite && pstrb[0];
    assign filt_n = (dominant_filter_time == 3'h7) ? 8'h8c : (8'(dominant_filter_time) + 8'h01) * 8'h0a;
    // Consecutive cycles the raw bus level has been dominant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 8'h00;
        end else if (!rx_bus_dominant_async) begin
            hi_cnt <= 8'h00;
        end else if (hi_cnt != 8'hff) begin
            hi_cnt <= hi_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_fd_fields: assert property (acc_wr && paddr == A_FD && !soft_reset |=>
        fd_tolerant_enable == $past(pwdata[0]) && dominant_filter_time == $past(pwdata[3:1])
        && receiver_filter_bypass == $past(pwdata[4])) else $error("fd config fields not loaded");
    chk_fd_hold: assert property ($changed(fd_tolerant_enable) |->
        ($past(acc_wr) && $past(paddr) == A_FD) || $past(soft_reset)) else $error("fd enable moved alone");
    chk_err_gated: assert property (!fd_tolerant_enable |-> error_counter_active)
        else $error("counter disabled without fd mode");
    chk_silence_clear: assert property (silence_timeout_expire |=> error_counter_active)
        else $error("silence timeout did not clear disable");
    chk_soft_clear: assert property (soft_reset |=> !fd_tolerant_enable && !receiver_filter_bypass
        && dominant_filter_time == 3'h0) else $error("soft reset left fd config");
    chk_fd_reserved: assert property (setup_rd && paddr == A_FD |=> prdata[31:6] == 26'h0)
        else $error("reserved fd bits not zero");
    chk_trim_locked: assert property ($changed(oscillator_trim_value) |->
        $past(acc_wr) && $past(paddr) == A_TRIM) else $error("trim changed without write");
    chk_trim_preset: assert property (setup_rd && paddr == A_TRIM |=> prdata[7] == TRIM_PRESET[7]
        && prdata[6:0] == oscillator_trim_value) else $error("trim readback wrong");
    chk_match_pulse: assert property (!rx_frame_valid |=> !wake_frame_match)
        else $error("match without frame");
    chk_filter_time: assert property ($rose(filtered_dominant) && fd_tolerant_enable
        && $past(fd_tolerant_enable) |-> hi_cnt >= filt_n) else $error("dominant filter too short");
    chk_pass_thru: assert property (!fd_tolerant_enable && !$past(fd_tolerant_enable, 3) && $past(presetn, 3)
        |-> filtered_dominant == $past(rx_bus_dominant_async, 3)) else $error("filter not transparent");
    cover property (wake_frame_match);
    cover property (!error_counter_active ##1 silence_timeout_expire);
    cover property ($rose(filtered_dominant) && fd_tolerant_enable);
endmodule : wake_frame_payload_fd_config_checker

bind wake_frame_payload_fd_config wake_frame_payload_fd_config_checker #(.ADDR_W(ADDR_W),
    .TRIM_PRESET(TRIM_PRESET)) u_chk (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .silence_timeout_expire(silence_timeout_expire),
    .rx_bus_dominant_async(rx_bus_dominant_async), .rx_frame_valid(rx_frame_valid),
    .fd_tolerant_enable(fd_tolerant_enable), .dominant_filter_time(dominant_filter_time),
    .receiver_filter_bypass(receiver_filter_bypass), .error_counter_active(error_counter_active),
    .oscillator_trim_value(oscillator_trim_value), .filtered_dominant(filtered_dominant),
    .wake_frame_match(wake_frame_match));

// File: tb/host_apb_master.sv
// Host software model driving the APB register port
`timescale 1ns/10ps
module host_apb_master #(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rd_data;
    logic rd_err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end
    // Called just after a rising edge; returns one edge after the release
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
endmodule : host_apb_master

// File: tb/wake_frame_payload_fd_config_tb.sv
// Self-checking bench for the wake configuration bank
`timescale 1ns/10ps
`include "wake_cfg_defs.svh"
module wake_frame_payload_fd_config_tb;
    import wake_cfg_pkg::*;
    localparam logic [7:0] TP = 8'hc5;
    localparam logic [7:0] FD = `WFC_IDX_FD_CFG;
    localparam logic [7:0] IDX [5] = '{`WFC_IDX_PAYLOAD4, `WFC_IDX_PAYLOAD3, `WFC_IDX_PAYLOAD2,
        `WFC_IDX_PAYLOAD1, `WFC_IDX_PAYLOAD0};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic soft_reset = 1'b0;
    logic expire = 1'b0;
    logic rx = 1'b0;
    logic fvalid = 1'b0;
    logic [3:0] fdlc = 4'h0;
    payload_t fdata = '0;
    logic psel, penable, pwrite, pready, pslverr, fd_en, bypass, err_act, rx_sel, filt, match;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] ftime;
    logic [6:0] trim;
    int miscompares = 0;
    int total_checks = 0;

    host_apb_master #(.ADDR_W(12)) host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    wake_frame_payload_fd_config #(.ADDR_W(12), .TRIM_PRESET(TP)) DUT (.pclk(pclk), .presetn(presetn),
        .soft_reset(soft_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .silence_timeout_expire(expire), .rx_bus_dominant_async(rx), .rx_frame_valid(fvalid),
        .rx_frame_dlc(fdlc), .rx_frame_data(fdata), .fd_tolerant_enable(fd_en),
        .dominant_filter_time(ftime), .receiver_filter_bypass(bypass), .error_counter_active(err_act),
        .wake_receiver_select(rx_sel), .oscillator_trim_value(trim), .filtered_dominant(filt),
        .wake_frame_match(match));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.xfer(1'b1, {2'b00, idx, 2'b00}, d);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        host.xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        check($sformatf("reg %h", idx), host.rd_data, {24'h0, e});
        check("pslverr", 32'(host.rd_err), 32'h0);
    endtask : rd
    task automatic frame(input logic [3:0] d, input payload_t p, input logic e);
        fdlc <= d;
        fdata <= p;
        fvalid <= 1'b1;
        @(posedge pclk);
        fvalid <= 1'b0;
        @(negedge pclk);
        check("match", 32'(match), 32'(e));
        @(posedge pclk);
    endtask : frame
    task automatic rx_hold(input logic v, input int n, input logic e);
        rx <= v;
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        check("filtered", 32'(filt), 32'(e));
        @(posedge pclk);
    endtask : rx_hold
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            rd(IDX[i], 8'h00);
        end
        rd(FD, 8'h00);
        rd(`WFC_IDX_TRIM, TP);
        for (int i = 0; i < 5; i++) begin
            wr(IDX[i], 8'h81 + 8'(i) * 8'h11);
        end
        for (int i = 0; i < 5; i++) begin
            rd(IDX[i], 8'h81 + 8'(i) * 8'h11);
        end
        wr(FD, 8'hff);
        rd(FD, 8'h3f);
        check("fd outputs", {26'h0, fd_en, ftime, bypass, err_act}, 32'h3e);
        for (int c = 0; c < 8; c++) begin
            wr(FD, {4'h0, 3'(c), 1'b1});
            check("filter time", 32'(ftime), 32'(c));
        end
        wr(FD, 8'h20);
        check("counter active", 32'(err_act), 32'h1);
        wr(FD, 8'h21);
        check("counter active", 32'(err_act), 32'h0);
        expire <= 1'b1;
        @(posedge pclk);
        expire <= 1'b0;
        @(posedge pclk);
        check("counter active", 32'(err_act), 32'h1);
        rd(FD, 8'h01);
        wr(`WFC_IDX_TRIM, {TP[7], 7'h15});
        check("trim locked", 32'(trim), 32'(TP[6:0]));
        wr(`WFC_IDX_TRIM_UNLOCK, 8'h03);
        // retrim only to exercise the lock
        wr(`WFC_IDX_TRIM, {TP[7], 7'h2a});
        check("trim", 32'(trim), 32'h2a);
        rd(`WFC_IDX_TRIM, {TP[7], 7'h2a});
        wr(`WFC_IDX_WAKE_OPT, 8'h80);
        check("rx select", 32'(rx_sel), 32'h1);
        host.xfer(1'b0, 12'h000, 8'h00);
        check("unmapped err", 32'(host.rd_err), 32'h1);
        check("unmapped data", host.rd_data, 32'h0);
        wr(`WFC_IDX_DLC, 8'h03);
        frame(4'h3, {8'h81, 8'h92, 8'ha3, 8'hb4, 8'hc5}, 1'b1);
        frame(4'h3, {8'h00, 8'h00, 8'ha3, 8'hb4, 8'hc5}, 1'b1);
        frame(4'h3, {8'h81, 8'h92, 8'h23, 8'hb4, 8'hc5}, 1'b0);
        frame(4'hb, {8'h81, 8'h92, 8'ha3, 8'hb4, 8'hc5}, 1'b0);
        wr(FD, 8'h11);
        rx_hold(1'b1, 5, 1'b0);
        rx_hold(1'b0, 4, 1'b0);
        rx_hold(1'b1, 9, 1'b0);
        rx_hold(1'b1, 8, 1'b1);
        rx_hold(1'b0, 4, 1'b0);
        wr(FD, 8'h00);
        rx_hold(1'b1, 4, 1'b1);
        rx_hold(1'b0, 4, 1'b0);
        wr(FD, 8'h3f);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        @(posedge pclk);
        rd(IDX[4], 8'h00);
        rd(FD, 8'h00);
        check("trim kept", 32'(trim), 32'h2a);
        end_of_test();
    end
endmodule : wake_frame_payload_fd_config_tb
